// ---- dual_adc_lvds_pkg.sv ----
`timescale 1ns/1ns
package dual_adc_lvds_pkg;
    localparam int SMP_W = 12;
    localparam int PAD_W = 14;
    localparam int LAT_CYC = 12;
    localparam int REF_PERIOD_NS = 10;
    localparam int WAKE_TIME_US = 100;
    localparam int WAKE_CYC_DEF = (WAKE_TIME_US * 1000) / REF_PERIOD_NS;
    localparam int WAKE_W = 16;
    localparam int STBY_W = 8;
    localparam logic [STBY_W-1:0] STBY_WAKE_CYC = 8'hc8;
    localparam logic [2:0] GAIN_DEF = 3'h1;
    localparam logic [2:0] GAIN_MAX = 3'h5;
    localparam logic FMT_TWOS = 1'b0;
    localparam logic [1:0] PAD_ZERO = 2'h0;
    localparam logic [3:0] BITS_12 = 4'hc;
    localparam logic [3:0] BITS_14 = 4'he;
    localparam logic [3:0] HALF_12 = 4'h6;
    localparam logic [3:0] HALF_14 = 4'h7;

    typedef enum logic [1:0] {
        ORDER_BYTE = 2'b00,
        ORDER_BIT = 2'b01,
        ORDER_WORD = 2'b10
    } order_t;

    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_WAKE = 2'b01,
        PWR_ON = 2'b10
    } pwr_t;

    typedef struct packed {
        logic twoWire;
        logic ser14;
        logic ddr;
        order_t order;
        logic lsbFirst;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{twoWire: 1'b0, ser14: 1'b0, ddr: 1'b1, order: ORDER_BYTE, lsbFirst: 1'b0};
endpackage

module lane_bit_pick
    import dual_adc_lvds_pkg::*;
(
    input wire logic [PAD_W-1:0] wordLow,
    input wire logic [PAD_W-1:0] wordHigh,
    input wire logic [3:0] slot,
    input wire cfg_t cfg,
    output logic bitLow,
    output logic bitHigh
);
    logic [3:0] fullLen;
    logic [3:0] halfLen;
    logic [3:0] seqIdx;
    logic [3:0] halfIdx;

    always_comb begin
        fullLen = cfg.ser14 ? BITS_14 : BITS_12;
        halfLen = cfg.ser14 ? HALF_14 : HALF_12;
        // lsb-first walks each lane upward, lanes themselves stay put
        seqIdx = cfg.lsbFirst ? slot : 4'(fullLen - 4'h1 - slot);
        halfIdx = cfg.lsbFirst ? slot : 4'(halfLen - 4'h1 - slot);
        bitLow = wordLow[seqIdx];
        bitHigh = 1'b0;
        if (cfg.twoWire) begin
            case (cfg.order)
                ORDER_BYTE: begin
                    bitLow = wordLow[halfIdx];
                    bitHigh = wordLow[4'(halfIdx + halfLen)];
                end
                ORDER_BIT: begin
                    bitLow = wordLow[{halfIdx[2:0], 1'b0}];
                    bitHigh = wordLow[{halfIdx[2:0], 1'b1}];
                end
                ORDER_WORD: begin
                    bitLow = wordLow[seqIdx];
                    bitHigh = wordHigh[seqIdx];
                end
                default: begin
                    bitLow = 1'b0;
                    bitHigh = 1'b0;
                end
            endcase
        end
    end
endmodule // lane_bit_pick

// ---- dual_adc_lvds_serializer.sv ----
`timescale 1ns/1ns
module dual_adc_lvds_serializer
    import dual_adc_lvds_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic serClk,
    input wire logic [SMP_W-1:0] sampleA,
    input wire logic [SMP_W-1:0] sampleB,
    input wire logic globalPowerdownBit,
    input wire logic [1:0] channelStandbyBits,
    input wire logic clockStopPin,
    input wire logic cfgWr,
    input wire logic twoWireSel,
    input wire logic ser14Sel,
    input wire logic ddrSel,
    input wire logic [1:0] bitOrderSel,
    input wire logic lsbFirstSel,
    input wire logic outputFormatSelect,
    input wire logic [2:0] gainSel,
    output logic [2:0] clockBufferGainField,
    output logic clockStopped,
    output logic dataValid,
    output logic [1:0] channelValid,
    output logic outDrive_b,
    output logic chanALaneLow,
    output logic chanALaneHigh,
    output logic chanBLaneLow,
    output logic chanBLaneHigh,
    output logic frameClkOut,
    output logic bitClkOut
);
    typedef struct packed {
        pwr_t pwr;
        logic [WAKE_W-1:0] wakeCnt;
        logic [1:0][STBY_W-1:0] stbyCnt;
        logic [1:0] chanOk;
        logic [LAT_CYC-1:0][SMP_W-1:0] pipeA;
        logic [LAT_CYC-1:0][SMP_W-1:0] pipeB;
        logic [1:0][PAD_W-1:0] cur;
        logic [1:0][PAD_W-1:0] prev;
        cfg_t cfg;
        logic fmt;
        logic [2:0] gain;
        logic stopS1;
        logic stopS2;
        logic req;
        logic ackS1;
        logic ackS2;
        logic [1:0][PAD_W-1:0] txCur;
        logic [1:0][PAD_W-1:0] txPrev;
        cfg_t txCfg;
    } ref_st_t;

    typedef struct packed {
        logic reqS1;
        logic reqS2;
        logic ack;
        logic [1:0][PAD_W-1:0] rxCur;
        logic [1:0][PAD_W-1:0] rxPrev;
        cfg_t rxCfg;
        logic [1:0][PAD_W-1:0] frCur;
        logic [1:0][PAD_W-1:0] frPrev;
        cfg_t frCfg;
        logic [3:0] slot;
        logic phase;
        logic frameClk;
        logic bitClk;
        logic [1:0][1:0] lanes;
    } lnk_st_t;

    ref_st_t r_r;
    ref_st_t r_nxt;
    lnk_st_t l_r;
    lnk_st_t l_nxt;
    logic [1:0] rstSync_r;
    logic rstRef_b;
    logic [1:0] lnkRst_r;
    logic lnkRst_b;
    logic pwrOff;
    logic [1:0][PAD_W-1:0] fmtWord;
    logic [1:0][SMP_W-1:0] pipeTail;
    logic [1:0][1:0] pickBits;
    logic [3:0] frameLen;
    logic [3:0] frameHigh;

    // reset release synchronised into each domain, assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_r <= 2'h0;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstRef_b = rstSync_r[1];

    always_ff @(posedge serClk or negedge rstRef_b) begin
        if (!rstRef_b) begin
            lnkRst_r <= 2'h0;
        end else begin
            lnkRst_r <= {lnkRst_r[0], 1'b1};
        end
    end
    assign lnkRst_b = lnkRst_r[1];

    assign pipeTail[0] = r_r.pipeA[LAT_CYC-1];
    assign pipeTail[1] = r_r.pipeB[LAT_CYC-1];
    // loss of clock is treated like a global power-down with the same wake time
    assign pwrOff = globalPowerdownBit | r_r.stopS2;

    always_comb begin
        r_nxt = r_r;
        r_nxt.stopS1 = clockStopPin;
        r_nxt.stopS2 = r_r.stopS1;
        case (r_r.pwr)
            PWR_OFF: begin
                if (!pwrOff) begin
                    r_nxt.pwr = PWR_WAKE;
                    r_nxt.wakeCnt = WAKE_W'(WAKE_CYC - 1);
                end
            end
            PWR_WAKE: begin
                if (pwrOff) begin
                    r_nxt.pwr = PWR_OFF;
                end else if (r_r.wakeCnt == '0) begin
                    r_nxt.pwr = PWR_ON;
                end else begin
                    r_nxt.wakeCnt = WAKE_W'(r_r.wakeCnt - 1'b1);
                end
            end
            PWR_ON: begin
                if (pwrOff) begin
                    r_nxt.pwr = PWR_OFF;
                end
            end
            default: r_nxt.pwr = PWR_OFF;
        endcase
        // conversion pipeline, fixed latency ahead of the serializer
        r_nxt.pipeA[0] = sampleA;
        r_nxt.pipeB[0] = sampleB;
        for (int i = 1; i < LAT_CYC; i++) begin
            r_nxt.pipeA[i] = r_r.pipeA[i-1];
            r_nxt.pipeB[i] = r_r.pipeB[i-1];
        end
        for (int c = 0; c < 2; c++) begin
            if (channelStandbyBits[c]) begin
                r_nxt.stbyCnt[c] = STBY_WAKE_CYC;
            end else if (r_r.stbyCnt[c] != '0) begin
                r_nxt.stbyCnt[c] = STBY_W'(r_r.stbyCnt[c] - 1'b1);
            end
            r_nxt.chanOk[c] = (r_r.pwr == PWR_ON) && !channelStandbyBits[c] && (r_r.stbyCnt[c] == '0);
            // raw core codes are offset binary; two's complement flips the sign bit
            fmtWord[c] = {PAD_ZERO, (r_r.fmt == FMT_TWOS) ? {~pipeTail[c][SMP_W-1], pipeTail[c][SMP_W-2:0]}
                                                          : pipeTail[c]};
            // a sleeping channel sends zeros, its lanes keep running
            r_nxt.cur[c] = r_r.chanOk[c] ? fmtWord[c] : '0;
            r_nxt.prev[c] = r_r.cur[c];
        end
        if (cfgWr) begin
            r_nxt.cfg.twoWire = twoWireSel;
            r_nxt.cfg.ser14 = ser14Sel;
            r_nxt.cfg.ddr = ddrSel;
            r_nxt.cfg.order = (bitOrderSel == ORDER_BIT) ? ORDER_BIT
                            : (bitOrderSel == ORDER_WORD) ? ORDER_WORD : ORDER_BYTE;
            r_nxt.cfg.lsbFirst = lsbFirstSel;
            r_nxt.fmt = outputFormatSelect;
            // out-of-range gain codes are ignored rather than wrapped
            if (gainSel <= GAIN_MAX) begin
                r_nxt.gain = gainSel;
            end
        end
        // toggle handshake: payload only changes once the link has taken the last one
        r_nxt.ackS1 = l_r.ack;
        r_nxt.ackS2 = r_r.ackS1;
        if (r_r.req == r_r.ackS2) begin
            r_nxt.txCur = r_r.cur;
            r_nxt.txPrev = r_r.prev;
            r_nxt.txCfg = r_r.cfg;
            r_nxt.req = ~r_r.req;
        end
    end

    always_ff @(posedge ref_clk or negedge rstRef_b) begin
        if (!rstRef_b) begin
            r_r <= '0;
            r_r.pwr <= PWR_WAKE;
            r_r.wakeCnt <= WAKE_W'(WAKE_CYC - 1);
            r_r.cfg <= CFG_RESET;
            r_r.txCfg <= CFG_RESET;
            r_r.fmt <= FMT_TWOS;
            r_r.gain <= GAIN_DEF;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign clockBufferGainField = r_r.gain;
    assign clockStopped = r_r.stopS2;
    assign dataValid = (r_r.pwr == PWR_ON);
    assign channelValid = r_r.chanOk;
    assign outDrive_b = (r_r.pwr == PWR_OFF);

    for (genvar c = 0; c < 2; c++) begin : g_pick
        lane_bit_pick u_pick (
            .wordLow((l_r.frCfg.twoWire && l_r.frCfg.order == ORDER_WORD) ? l_r.frPrev[c] : l_r.frCur[c]),
            .wordHigh(l_r.frCur[c]),
            .slot(l_r.slot),
            .cfg(l_r.frCfg),
            .bitLow(pickBits[c][0]),
            .bitHigh(pickBits[c][1])
        );
    end

    always_comb begin
        l_nxt = l_r;
        l_nxt.reqS1 = r_r.req;
        l_nxt.reqS2 = l_r.reqS1;
        if (l_r.reqS2 != l_r.ack) begin
            l_nxt.rxCur = r_r.txCur;
            l_nxt.rxPrev = r_r.txPrev;
            l_nxt.rxCfg = r_r.txCfg;
            l_nxt.ack = l_r.reqS2;
        end
        // slots per frame: full word on one lane or in word order, half word on each of two otherwise
        if (!l_r.frCfg.twoWire || l_r.frCfg.order == ORDER_WORD) begin
            frameLen = l_r.frCfg.ser14 ? BITS_14 : BITS_12;
        end else begin
            frameLen = l_r.frCfg.ser14 ? HALF_14 : HALF_12;
        end
        frameHigh = 4'((frameLen + 4'h1) >> 1);
        // each bit slot spans two link cycles so sdr gets one full clock per bit
        l_nxt.phase = ~l_r.phase;
        if (l_r.phase) begin
            if (l_r.slot == 4'(frameLen - 4'h1)) begin
                l_nxt.slot = '0;
                l_nxt.frCur = l_r.rxCur;
                l_nxt.frPrev = l_r.rxPrev;
                l_nxt.frCfg = l_r.rxCfg;
            end else begin
                l_nxt.slot = 4'(l_r.slot + 4'h1);
            end
        end
        if (!l_r.phase) begin
            l_nxt.lanes = pickBits;
            l_nxt.frameClk = (l_r.slot < frameHigh);
        end
        // sdr: one rising edge per bit; ddr: one edge of either kind per bit
        l_nxt.bitClk = l_r.frCfg.ddr ? (l_r.phase ? l_r.bitClk : ~l_r.bitClk) : l_r.phase;
    end

    always_ff @(posedge serClk or negedge lnkRst_b) begin
        if (!lnkRst_b) begin
            l_r <= '0;
            l_r.rxCfg <= CFG_RESET;
            l_r.frCfg <= CFG_RESET;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign chanALaneLow = l_r.lanes[0][0];
    assign chanALaneHigh = l_r.lanes[0][1];
    assign chanBLaneLow = l_r.lanes[1][0];
    assign chanBLaneHigh = l_r.lanes[1][1];
    assign frameClkOut = l_r.frameClk;
    assign bitClkOut = l_r.bitClk;

    sequence seqStbyRelease;
        $fell(channelStandbyBits[0]) && r_r.pwr == PWR_ON;
    endsequence

    sequence seqStbyHeldLow;
        !r_r.chanOk[0] [*8];
    endsequence

    AST_PDN_FLOAT: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        globalPowerdownBit |=> outDrive_b && !dataValid)
        else $error("outputs still driven during global power-down");

    AST_WAKE_COUNT: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        $rose(dataValid) |-> $past(r_r.pwr) == PWR_WAKE && $past(r_r.wakeCnt) == '0)
        else $error("data valid before wake count expired");

    AST_WAKE_RESTART: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        r_r.pwr == PWR_OFF && !pwrOff |=> r_r.pwr == PWR_WAKE && r_r.wakeCnt == WAKE_W'(WAKE_CYC - 1))
        else $error("wake counter not reloaded on power return");

    AST_STBY_ZERO: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        channelStandbyBits[0] |=> !r_r.chanOk[0] ##1 r_r.cur[0] == '0)
        else $error("standby channel still sends data");

    AST_STBY_HOLD: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        seqStbyRelease |=> seqStbyHeldLow)
        else $error("standby channel woke too early");

    AST_STBY_BOUND: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        seqStbyRelease ##1 (!channelStandbyBits[0] && r_r.pwr == PWR_ON) [*8]
        |-> ##[190:200] (r_r.chanOk[0] || channelStandbyBits[0] || r_r.pwr != PWR_ON))
        else $error("standby channel not back within 200 clocks");

    AST_GAIN_RANGE: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        r_r.gain <= GAIN_MAX)
        else $error("clock buffer gain outside its six settings");

    AST_LATENCY: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        dataValid |-> r_r.pipeA[LAT_CYC-1] == $past(sampleA, 12))
        else $error("conversion latency is not twelve clocks");

    AST_FORMAT: assert property (@(posedge ref_clk) disable iff (!rstRef_b)
        r_r.chanOk[0] && r_r.fmt == FMT_TWOS |=> r_r.cur[0][SMP_W-1] != $past(pipeTail[0][SMP_W-1]))
        else $error("two's complement sign bit not inverted");

    AST_FRAME_START: assert property (@(posedge serClk) disable iff (!lnkRst_b)
        $rose(l_r.frameClk) |-> $past(l_r.slot) == '0)
        else $error("frame clock rose away from word start");

    AST_SLOT_WRAP: assert property (@(posedge serClk) disable iff (!lnkRst_b)
        l_r.phase && l_r.slot == 4'(frameLen - 4'h1) |=> l_r.slot == '0)
        else $error("frame length wrong for the selected mode");

    AST_PAD_ZERO: assert property (@(posedge serClk) disable iff (!lnkRst_b)
        !l_r.phase && !l_r.frCfg.twoWire && l_r.frCfg.ser14 && !l_r.frCfg.lsbFirst && l_r.slot < 4'h2
        |=> !chanALaneLow && !chanBLaneLow)
        else $error("14x pad bits not zero");

    AST_ONEWIRE_IDLE: assert property (@(posedge serClk) disable iff (!lnkRst_b)
        !l_r.phase && !l_r.frCfg.twoWire |=> !chanALaneHigh && !chanBLaneHigh)
        else $error("second lane active in one-wire mode");

    AST_SDR_CLK: assert property (@(posedge serClk) disable iff (!lnkRst_b)
        !l_r.frCfg.ddr && !$past(l_r.frCfg.ddr) && !$past(l_r.frCfg.ddr, 2) |-> bitClkOut != $past(bitClkOut))
        else $error("sdr bit clock did not toggle");
endmodule // dual_adc_lvds_serializer

// ---- lvds_rx_model.sv ----
`timescale 1ns/1ns
module lvds_rx_model (
    input wire logic serClk,
    input wire logic rst_b,
    input wire logic laneAL,
    input wire logic laneAH,
    input wire logic laneBL,
    input wire logic laneBH,
    input wire logic frameClk,
    input wire logic bitClk,
    input wire logic [3:0] nSlots,
    output logic [13:0] wordAL,
    output logic [13:0] wordAH,
    output logic [13:0] wordBL,
    output logic [13:0] wordBH,
    output logic [7:0] wordCount,
    output logic [7:0] framePeriod,
    output logic [7:0] bitToggles
);
    logic prevFrame, prevBit, phase, active;
    logic [3:0] slot;
    logic [7:0] cyc, tog;
    logic [13:0] sAL, sAH, sBL, sBH;
    // one sample per two-cycle slot, taken on its first cycle; a short frame is dropped at the next rise
    always @(posedge serClk or negedge rst_b) begin
        if (!rst_b) begin
            {prevFrame, prevBit, phase, active, slot, cyc, tog} <= '0;
            {sAL, sAH, sBL, sBH} <= '0;
            {wordAL, wordAH, wordBL, wordBH} <= '0;
            {wordCount, framePeriod, bitToggles} <= '0;
        end else begin
            prevFrame <= frameClk;
            prevBit <= bitClk;
            cyc <= cyc + 8'h01;
            tog <= tog + {7'h0, bitClk ^ prevBit};
            if (frameClk && !prevFrame) begin
                framePeriod <= cyc;
                bitToggles <= tog;
                cyc <= 8'h01;
                tog <= {7'h0, bitClk ^ prevBit};
                {sAL, sAH, sBL, sBH} <= {13'h0, laneAL, 13'h0, laneAH, 13'h0, laneBL, 13'h0, laneBH};
                slot <= 4'h1;
                phase <= 1'b1;
                active <= 1'b1;
            end else if (active && phase) begin
                phase <= 1'b0;
            end else if (active) begin
                sAL <= {sAL[12:0], laneAL};
                sAH <= {sAH[12:0], laneAH};
                sBL <= {sBL[12:0], laneBL};
                sBH <= {sBH[12:0], laneBH};
                slot <= slot + 4'h1;
                phase <= 1'b1;
                if (slot == nSlots - 4'h1) begin
                    wordAL <= {sAL[12:0], laneAL};
                    wordAH <= {sAH[12:0], laneAH};
                    wordBL <= {sBL[12:0], laneBL};
                    wordBH <= {sBH[12:0], laneBH};
                    wordCount <= wordCount + 8'h01;
                    active <= 1'b0;
                end
            end
        end
    end
endmodule // lvds_rx_model

// ---- test_dual_adc_lvds_serializer.sv ----
`timescale 1ns/1ns
module test_dual_adc_lvds_serializer
    import dual_adc_lvds_pkg::*;
;
    localparam int WAKE_SIM = 20;
    logic ref_clk, serClk, rst_b, globalPowerdownBit, clockStopPin, cfgWr, twoWireSel, ser14Sel, ddrSel;
    logic lsbFirstSel, outputFormatSelect, clockStopped, dataValid, outDrive_b, frameClkOut, bitClkOut;
    logic chanALaneLow, chanALaneHigh, chanBLaneLow, chanBLaneHigh;
    logic [SMP_W-1:0] sampleA, sampleB;
    logic [1:0] channelStandbyBits, bitOrderSel, channelValid;
    logic [2:0] gainSel, clockBufferGainField;
    logic [3:0] nSlots;
    logic [13:0] wordAL, wordAH, wordBL, wordBH;
    logic [7:0] wordCount, framePeriod, bitToggles;
    int n_mismatch, checks_done;

    dual_adc_lvds_serializer #(.WAKE_CYC(WAKE_SIM)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .serClk(serClk),
        .sampleA(sampleA), .sampleB(sampleB), .globalPowerdownBit(globalPowerdownBit),
        .channelStandbyBits(channelStandbyBits), .clockStopPin(clockStopPin), .cfgWr(cfgWr),
        .twoWireSel(twoWireSel), .ser14Sel(ser14Sel), .ddrSel(ddrSel), .bitOrderSel(bitOrderSel),
        .lsbFirstSel(lsbFirstSel), .outputFormatSelect(outputFormatSelect), .gainSel(gainSel),
        .clockBufferGainField(clockBufferGainField), .clockStopped(clockStopped), .dataValid(dataValid),
        .channelValid(channelValid), .outDrive_b(outDrive_b), .chanALaneLow(chanALaneLow),
        .chanALaneHigh(chanALaneHigh), .chanBLaneLow(chanBLaneLow), .chanBLaneHigh(chanBLaneHigh),
        .frameClkOut(frameClkOut), .bitClkOut(bitClkOut));
    lvds_rx_model u_rx (.serClk(serClk), .rst_b(rst_b), .laneAL(chanALaneLow), .laneAH(chanALaneHigh),
        .laneBL(chanBLaneLow), .laneBH(chanBLaneHigh), .frameClk(frameClkOut), .bitClk(bitClkOut),
        .nSlots(nSlots), .wordAL(wordAL), .wordAH(wordAH), .wordBL(wordBL), .wordBH(wordBH),
        .wordCount(wordCount), .framePeriod(framePeriod), .bitToggles(bitToggles));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        serClk = 1'b0;
        #7;
        forever #15 serClk = ~serClk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic timeout(input int cnt);
        $display("Error at %0t: wait timed out after %h cycles, expected %h", $time, cnt, 0);
        n_mismatch++;
        tally_and_finish();
    endtask

    task automatic setCfg(input logic tw, s14, ddr, input logic [1:0] ord, input logic lsb, fmt,
                          input logic [2:0] gain);
        @(negedge ref_clk);
        {twoWireSel, ser14Sel, ddrSel, bitOrderSel, lsbFirstSel, outputFormatSelect} = {tw, s14, ddr, ord, lsb, fmt};
        gainSel = gain;
        cfgWr = 1'b1;
        @(negedge ref_clk);
        cfgWr = 1'b0;
    endtask

    task automatic waitHigh(input logic useChan, output int cnt);
        cnt = 0;
        while ((useChan ? channelValid[0] : dataValid) !== 1'b1) begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > 2000) timeout(cnt);
        end
    endtask

    task automatic waitWords();
        logic [7:0] start;
        int cnt;
        start = wordCount;
        cnt = 0;
        while (8'(wordCount - start) < 8'h03) begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > 3000) timeout(cnt);
        end
    endtask

    // lane word in arrival order, first bit at the top of the used width
    function automatic logic [13:0] laneExp(logic [11:0] smp, logic fmt, tw, s14, logic [1:0] ord, logic lsb, hi);
        logic [13:0] d, r, q;
        int h, n;
        d = {2'h0, fmt ? smp : (smp ^ 12'h800)};
        h = s14 ? 7 : 6;
        n = 2 * h;
        r = '0;
        q = '0;
        if (!tw) r = hi ? 14'h0 : d;
        else if (ord == ORDER_WORD) r = d;
        else begin
            n = h;
            for (int i = 0; i < h; i++) r[i] = (ord == ORDER_BIT) ? d[2 * i + int'(hi)] : d[i + h * int'(hi)];
        end
        for (int i = 0; i < n; i++) q[i] = r[n - 1 - i];
        return lsb ? q : r;
    endfunction

    task automatic runMode(input logic tw, s14, ddr, input logic [1:0] ord, input logic lsb, fmt);
        int n;
        n = (s14 ? 14 : 12) / ((tw && ord != ORDER_WORD) ? 2 : 1);
        setCfg(tw, s14, ddr, ord, lsb, fmt, 3'h1);
        nSlots = 4'(n);
        repeat (80) @(negedge ref_clk);
        waitWords();
        chk({2'h0, wordAL}, {2'h0, laneExp(sampleA, fmt, tw, s14, ord, lsb, 1'b0)});
        chk({2'h0, wordAH}, {2'h0, laneExp(sampleA, fmt, tw, s14, ord, lsb, 1'b1)});
        chk({2'h0, wordBL}, {2'h0, laneExp(sampleB, fmt, tw, s14, ord, lsb, 1'b0)});
        chk({2'h0, wordBH}, {2'h0, laneExp(sampleB, fmt, tw, s14, ord, lsb, 1'b1)});
        chk({8'h0, framePeriod}, 16'(2 * n));
        chk({8'h0, bitToggles}, 16'(ddr ? n : 2 * n));
    endtask

    task automatic tReset();
        int cnt;
        waitHigh(1'b0, cnt);
        chk({13'h0, clockBufferGainField}, {13'h0, GAIN_DEF});
        chk({15'h0, outDrive_b}, 16'h0000);
    endtask

    task automatic tGain();
        for (int g = 0; g < 8; g++) begin
            setCfg(1'b0, 1'b0, 1'b1, ORDER_BYTE, 1'b0, 1'b0, 3'(g));
            chk({13'h0, clockBufferGainField}, 16'(g > 5 ? 5 : g));
        end
    endtask

    task automatic tOneWire();
        runMode(1'b0, 1'b0, 1'b1, ORDER_BYTE, 1'b0, 1'b0);
        runMode(1'b0, 1'b0, 1'b1, ORDER_BYTE, 1'b1, 1'b0);
        runMode(1'b0, 1'b1, 1'b1, ORDER_BYTE, 1'b0, 1'b1);
    endtask

    // two-wire as the system would pick for fast sampling
    task automatic tTwoWire();
        runMode(1'b1, 1'b0, 1'b1, ORDER_BYTE, 1'b0, 1'b0);
        runMode(1'b1, 1'b1, 1'b0, ORDER_BYTE, 1'b1, 1'b0);
        runMode(1'b1, 1'b0, 1'b0, ORDER_BIT, 1'b0, 1'b1);
        runMode(1'b1, 1'b1, 1'b1, ORDER_BIT, 1'b1, 1'b0);
        runMode(1'b1, 1'b0, 1'b1, ORDER_WORD, 1'b0, 1'b0);
        runMode(1'b1, 1'b1, 1'b1, ORDER_WORD, 1'b1, 1'b1);
    endtask

    task automatic tStandby();
        int cnt;
        channelStandbyBits = 2'b01;
        repeat (3) @(negedge ref_clk);
        chk({14'h0, channelValid}, 16'h0002);
        chk({14'h0, outDrive_b, dataValid}, 16'h0001);
        channelStandbyBits = 2'b00;
        waitHigh(1'b1, cnt);
        chk({15'h0, cnt >= 195 && cnt <= 205}, 16'h0001);
        channelStandbyBits = 2'b10;
        repeat (3) @(negedge ref_clk);
        chk({14'h0, channelValid}, 16'h0001);
        channelStandbyBits = 2'b00;
        repeat (220) @(negedge ref_clk);
        chk({14'h0, channelValid}, 16'h0003);
    endtask

    task automatic tPower();
        int cnt;
        globalPowerdownBit = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({14'h0, outDrive_b, dataValid}, 16'h0002);
        globalPowerdownBit = 1'b0;
        waitHigh(1'b0, cnt);
        chk({15'h0, cnt >= WAKE_SIM && cnt <= WAKE_SIM + 3}, 16'h0001);
        clockStopPin = 1'b1;
        repeat (5) @(negedge ref_clk);
        chk({13'h0, clockStopped, outDrive_b, dataValid}, 16'h0006);
        clockStopPin = 1'b0;
        waitHigh(1'b0, cnt);
        chk({15'h0, cnt >= WAKE_SIM && cnt <= WAKE_SIM + 6}, 16'h0001);
        runMode(1'b1, 1'b0, 1'b1, ORDER_BYTE, 1'b0, 1'b0);
    endtask

    initial begin
        rst_b = 1'b0;
        sampleA = 12'h9c5; // held constant so the pipeline delay does not matter
        sampleB = 12'h36a;
        {globalPowerdownBit, clockStopPin, cfgWr, twoWireSel, ser14Sel, lsbFirstSel, outputFormatSelect} = '0;
        ddrSel = 1'b1;
        bitOrderSel = ORDER_BYTE;
        channelStandbyBits = 2'b00;
        gainSel = 3'h1;
        nSlots = 4'hc;
        n_mismatch = 0;
        checks_done = 0;
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        tReset();
        tGain();
        tOneWire();
        tTwoWire();
        tStandby();
        tPower();
        tally_and_finish();
    end
endmodule // test_dual_adc_lvds_serializer
